// file: core/ldsc_pkg.sv
// package: constants and types for the load diagnostic and sense control block
package ldsc_pkg;

    // -----------------------------------------------------------------
    // register map (word addresses on the plain port)
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_CH0_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_CH1_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_GENERAL    = 4'h2;
    localparam logic [3:0] ADDR_OVERCUR    = 4'h3;
    localparam logic [3:0] ADDR_FAULT_CH0  = 4'h4;
    localparam logic [3:0] ADDR_FAULT_CH1  = 4'h5;
    localparam logic [3:0] ADDR_STATUS     = 4'h6;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int CFG_DIR_DIS_BIT   = 5;
    localparam int CFG_OS_DIS_BIT    = 6;
    localparam int CFG_OLOFF_DIS_BIT = 7;
    localparam int CFG_ON_OPEN_LOAD_DISABLE_BIT  = 8;
    localparam int CFG_FAST_SLEW_BIT = 0;
    localparam int GEN_SENSE0_BIT    = 0;
    localparam int GEN_SENSE1_BIT    = 1;
    localparam int GEN_TH_EN_BIT     = 2;
    localparam int OCR_RATIO_BIT     = 0;
    localparam int FLT_OS_BIT        = 0;
    localparam int FLT_OLOFF_BIT     = 1;
    localparam int FLT_OLON_BIT      = 2;

    // -----------------------------------------------------------------
    // reset values
    // -----------------------------------------------------------------
    localparam logic [15:0] RST_CONFIG  = 16'h0000;
    localparam logic [15:0] RST_GENERAL = 16'h0000;
    localparam logic [15:0] RST_OVERCUR = 16'h0000;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int  CLK_PERIOD_PS     = 4000;
    localparam longint OLLED_PERIOD_MS = 150;
    localparam longint OLLED_CYCLES   = (OLLED_PERIOD_MS * 64'd1000000000) / CLK_PERIOD_PS;
    localparam int  SETTLE_NS         = 40;
    localparam int  SETTLE_CYCLES     = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] SEL_CH0    = 2'h1;
    localparam logic [1:0] SEL_CH1    = 2'h2;
    localparam logic [1:0] SEL_TEMP   = 2'h3;
    localparam logic [1:0] SEL_NONE   = 2'h0;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SNS_IDLE   = 2'b00,
        SNS_SETTLE = 2'b01,
        SNS_VALID  = 2'b10,
        SNS_HOLD   = 2'b11
    } ldsc_sns_state_t;

    typedef struct packed
    {
        logic os_over_thr;
        logic oloff_over_thr;
        logic olon_under_thr;
    } ldsc_comp_t;

    typedef struct packed
    {
        logic on_open_load_flag;
        logic off_open_load_flag;
        logic short_to_supply_flag;
    } ldsc_flags_t;

endpackage

// file: core/ldsc_top.sv
// module: per-channel load diagnostics, fault latching and sense control
`timescale 1ns/10ps
`default_nettype none

module ldsc_top
    import ldsc_pkg::*;
#(
    parameter longint OLLED_CYC = OLLED_CYCLES,
    parameter int     SNS_W     = 12
)
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // channel control sources
    input  wire logic [1:0]        direct_in,
    input  wire logic [1:0]        pwm_on,
    // analog comparator results per channel (asynchronous)
    input  wire ldsc_comp_t [1:0]  comp_in,
    input  wire logic [1:0]        oc_window,
    // sense sample values
    input  wire logic [SNS_W-1:0]  cur_sense0,
    input  wire logic [SNS_W-1:0]  cur_sense1,
    input  wire logic [SNS_W-1:0]  temp_sense,
    // outputs
    output logic      [1:0]        chan_on,
    output logic                   fault_pin_n,
    output logic                   sense_valid_pin_n,
    output logic      [SNS_W-1:0]  sense_out,
    output logic      [1:0]        sense_ratio_low,
    output logic                   sense_enable
);

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    logic [15:0]        channel_config_reg [2];
    logic [15:0]        general_config_reg;
    logic [15:0]        overcurrent_config_reg;
    ldsc_flags_t [1:0]  fault_flags_reg;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            channel_config_reg[0]  <= RST_CONFIG;
            channel_config_reg[1]  <= RST_CONFIG;
            general_config_reg     <= RST_GENERAL;
            overcurrent_config_reg <= RST_OVERCUR;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_CH0_CONFIG)
                channel_config_reg[0] <= reg_wdata;
            else if (reg_addr == ADDR_CH1_CONFIG)
                channel_config_reg[1] <= reg_wdata;
            else if (reg_addr == ADDR_GENERAL)
                general_config_reg <= reg_wdata;
            else if (reg_addr == ADDR_OVERCUR)
                overcurrent_config_reg <= reg_wdata;
        end
    end

    // -----------------------------------------------------------------
    // input synchronisers: three stages, change taken when 2 and 3 agree
    // -----------------------------------------------------------------
    logic [4:0] sync1 [2];
    logic [4:0] sync2 [2];
    logic [4:0] sync3 [2];
    logic [4:0] clean [2];

    always_ff @(posedge sys_clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (sys_rst)
            begin
                sync1[c] <= 5'h00;
                sync2[c] <= 5'h00;
                sync3[c] <= 5'h00;
                clean[c] <= 5'h00;
            end
            else
            begin
                sync1[c] <= {direct_in[c], oc_window[c], comp_in[c]};
                sync2[c] <= sync1[c];
                sync3[c] <= sync2[c];
                for (int b = 0; b < 5; b++)
                    if (sync2[c][b] == sync3[c][b])
                        clean[c][b] <= sync3[c][b];
            end
        end
    end

    // -----------------------------------------------------------------
    // per-channel diagnostics
    // -----------------------------------------------------------------
    logic [1:0]  chan_on_d;
    logic [1:0]  turn_off;
    logic [1:0]  turn_on;
    logic [1:0]  live_fault;
    logic [1:0]  olon_event;
    logic [1:0]  olon_event_ok;
    logic [1:0]  olon_ok_seen;
    logic [63:0] olled_cnt [2];
    logic [1:0]  olled_due;
    logic [1:0]  olon_live;
    logic [1:0]  rd_fault;
    logic        low_ratio;

    assign low_ratio = overcurrent_config_reg[OCR_RATIO_BIT];

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            // internal source when direct input disabled
            chan_on[c] = channel_config_reg[c][CFG_DIR_DIS_BIT] ? pwm_on[c]
                                                                : clean[c][4];
            turn_off[c]  = chan_on_d[c] & ~chan_on[c];
            turn_on[c]   = ~chan_on_d[c] & chan_on[c];
            olled_due[c] = (olled_cnt[c] >= 64'(OLLED_CYC));
            rd_fault[c]  = reg_rd && (reg_addr == (c == 0 ? ADDR_FAULT_CH0 : ADDR_FAULT_CH1));
            // low ratio: sampled at turnoff only with fast slew
            olon_event[c] = low_ratio && channel_config_reg[c][CFG_FAST_SLEW_BIT]
                            && !channel_config_reg[c][CFG_ON_OPEN_LOAD_DISABLE_BIT]
                            && turn_off[c]
                            && (channel_config_reg[c][CFG_DIR_DIS_BIT] ? olled_due[c]
                                                                       : 1'b1);
            olon_event_ok[c] = olon_event[c] && !clean[c][0];
            // high ratio continuous check during on state
            olon_live[c] = !low_ratio && chan_on[c] && clean[c][0]
                           && !channel_config_reg[c][CFG_ON_OPEN_LOAD_DISABLE_BIT];
            live_fault[c] =
                (!chan_on[c] && clean[c][2] && !channel_config_reg[c][CFG_OS_DIS_BIT])
             || (!chan_on[c] && clean[c][1] && !channel_config_reg[c][CFG_OLOFF_DIS_BIT])
             || olon_live[c];
        end
    end

    // periodic check timer; runs also at full duty
    always_ff @(posedge sys_clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (sys_rst)
                olled_cnt[c] <= 64'h0;
            else if (olon_event[c])
                olled_cnt[c] <= 64'h0;
            else if (!olled_due[c])
                olled_cnt[c] <= olled_cnt[c] + 64'h1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            chan_on_d <= 2'b00;
        else
            chan_on_d <= chan_on;
    end

    // latched flags; a set in the read cycle wins
    always_ff @(posedge sys_clk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (sys_rst)
            begin
                fault_flags_reg[c] <= '0;
                olon_ok_seen[c]    <= 1'b0;
            end
            else
            begin
                // short to supply: detected only while off, never turns off
                if (!chan_on[c] && clean[c][2] && !channel_config_reg[c][CFG_OS_DIS_BIT])
                    fault_flags_reg[c].short_to_supply_flag <= 1'b1;
                else if (rd_fault[c])
                    fault_flags_reg[c].short_to_supply_flag <= 1'b0;
                if (!chan_on[c] && clean[c][1] && !channel_config_reg[c][CFG_OLOFF_DIS_BIT])
                    fault_flags_reg[c].off_open_load_flag <= 1'b1;
                else if (rd_fault[c])
                    fault_flags_reg[c].off_open_load_flag <= 1'b0;
                if (olon_live[c] || (olon_event[c] && clean[c][0]))
                    fault_flags_reg[c].on_open_load_flag <= 1'b1;
                else if (rd_fault[c])
                begin
                    if (!low_ratio && !chan_on[c])
                        fault_flags_reg[c].on_open_load_flag <= 1'b0;
                    else if (!low_ratio && !clean[c][0])
                        fault_flags_reg[c].on_open_load_flag <= 1'b0;
                    else if (low_ratio && olon_ok_seen[c])
                        fault_flags_reg[c].on_open_load_flag <= 1'b0;
                end
                if (olon_event_ok[c])
                    olon_ok_seen[c] <= 1'b1;
                else if (olon_event[c] || rd_fault[c])
                    olon_ok_seen[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            fault_pin_n <= 1'b1;
        else
            fault_pin_n <= ~(|live_fault);
    end

    // -----------------------------------------------------------------
    // sense control
    // -----------------------------------------------------------------
    ldsc_sns_state_t   sns_state;
    logic [7:0]        settle_cnt;
    logic [1:0]        sel;
    logic [1:0]        sel_d;
    logic              sel_ch;
    logic              th_mode;
    logic              oc_act;
    logic [SNS_W-1:0]  held;
    logic [SNS_W-1:0]  live_cur;

    assign sel     = {general_config_reg[GEN_SENSE1_BIT], general_config_reg[GEN_SENSE0_BIT]};
    assign sel_ch  = (sel == SEL_CH1);
    assign th_mode = general_config_reg[GEN_TH_EN_BIT];
    assign oc_act  = sel_ch ? clean[1][3] : clean[0][3];
    assign live_cur = sel_ch ? cur_sense1 : cur_sense0;
    assign sense_ratio_low = {low_ratio, low_ratio};
    assign sense_enable = ~oc_act;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sns_state  <= SNS_IDLE;
            settle_cnt <= 8'h00;
            held       <= '0;
            sel_d      <= SEL_NONE;
        end
        else
        begin
            sel_d <= sel;
            if (sel != sel_d)
            begin
                sns_state <= SNS_IDLE;
                held      <= '0;
            end
            else if (oc_act)
                sns_state <= SNS_IDLE;
            else
            begin
                case (sns_state)
                    SNS_IDLE, SNS_HOLD:
                        if (chan_on[sel_ch] && (sel == SEL_CH0 || sel == SEL_CH1))
                        begin
                            sns_state  <= SNS_SETTLE;
                            settle_cnt <= 8'h00;
                        end
                    SNS_SETTLE:
                        if (!chan_on[sel_ch])
                            sns_state <= SNS_IDLE;
                        else if (settle_cnt >= 8'(SETTLE_CYCLES - 1))
                            sns_state <= SNS_VALID;
                        else
                            settle_cnt <= settle_cnt + 8'h01;
                    SNS_VALID:
                    begin
                        // keep the last on-state sample, not the off value
                        if (chan_on[sel_ch])
                            held <= live_cur;
                        if (!chan_on[sel_ch])
                            sns_state <= th_mode ? SNS_HOLD : SNS_IDLE;
                    end
                    default:
                        sns_state <= SNS_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sense_out         <= '0;
            sense_valid_pin_n <= 1'b1;
        end
        else
        begin
            sense_valid_pin_n <= ~(sns_state == SNS_VALID) | oc_act;
            if (sel == SEL_TEMP)
                sense_out <= temp_sense;
            else if (oc_act || sel == SEL_NONE)
                sense_out <= '0;
            else if (sns_state == SNS_VALID)
                sense_out <= live_cur;
            else if (sns_state == SNS_HOLD)
                sense_out <= held;
            else
                sense_out <= '0;
        end
    end

    // -----------------------------------------------------------------
    // register read-back, one cycle after the strobe
    // -----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            if (reg_addr == ADDR_CH0_CONFIG)
                reg_rdata <= channel_config_reg[0];
            else if (reg_addr == ADDR_CH1_CONFIG)
                reg_rdata <= channel_config_reg[1];
            else if (reg_addr == ADDR_GENERAL)
                reg_rdata <= general_config_reg;
            else if (reg_addr == ADDR_OVERCUR)
                reg_rdata <= overcurrent_config_reg;
            else if (reg_addr == ADDR_FAULT_CH0)
                reg_rdata <= {13'h0000, fault_flags_reg[0]};
            else if (reg_addr == ADDR_FAULT_CH1)
                reg_rdata <= {13'h0000, fault_flags_reg[1]};
            else if (reg_addr == ADDR_STATUS)
                reg_rdata <= {11'h000, sns_state, fault_pin_n, chan_on};
            else
                reg_rdata <= 16'h0000;
        end
        else
            reg_rdata <= 16'h0000;
    end

endmodule

`default_nettype wire

// file: sim/ldsc_load_model.sv
// partner: switched loads and sense currents facing the block
`timescale 1ns/10ps
`default_nettype none
module ldsc_load_model
    import ldsc_pkg::*;
(
    // channel state from the block
    input  wire logic [1:0]  chan_on,
    // load faults and levels set by the bench
    input  wire logic [1:0]  load_open,
    input  wire logic [1:0]  load_short,
    input  wire logic [11:0] level0,
    input  wire logic [11:0] level1,
    // comparators and sense currents
    output ldsc_comp_t [1:0] comp_in,
    output logic      [11:0] cur_sense0,
    output logic      [11:0] cur_sense1
);
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            comp_in[c].os_over_thr    = load_short[c] && !chan_on[c];
            comp_in[c].oloff_over_thr = load_open[c] && !chan_on[c];
            comp_in[c].olon_under_thr = load_open[c] && chan_on[c];
        end
    end
    // no current while off or open
    assign cur_sense0 = (chan_on[0] && !load_open[0]) ? level0 : 12'h000;
    assign cur_sense1 = (chan_on[1] && !load_open[1]) ? level1 : 12'h000;
endmodule
`default_nettype wire

// file: sim/ldsc_properties.sv
// checker: port-level properties of the diagnostic and sense block
`timescale 1ns/10ps
`default_nettype none
module ldsc_properties
    import ldsc_pkg::*;
#(
    parameter int SNS_W = 12
)
(
    // clock and reset
    input wire logic             sys_clk,
    input wire logic             sys_rst,
    // register port
    input wire logic [3:0]       reg_addr,
    input wire logic [15:0]      reg_wdata,
    input wire logic             reg_wr,
    // control and status
    input wire logic [1:0]       pwm_on,
    input wire ldsc_comp_t [1:0] comp_in,
    input wire logic [1:0]       oc_window,
    input wire logic [1:0]       chan_on,
    input wire logic             fault_pin_n,
    input wire logic             sense_valid_pin_n,
    input wire logic [SNS_W-1:0] sense_out,
    input wire logic [1:0]       sense_ratio_low,
    input wire logic             sense_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------
    // shadow of written configuration
    // ----------
    logic [15:0] cfg0;
    logic [15:0] gen;
    logic        low;
    logic        run0;
    logic [5:0]  on_cnt;
    logic [5:0]  off_cnt;
    assign run0 = chan_on[0] && !oc_window[0] && gen[1:0] == SEL_CH0;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg0 <= RST_CONFIG;
            gen  <= RST_GENERAL;
            low  <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_CH0_CONFIG)
                cfg0 <= reg_wdata;
            if (reg_addr == ADDR_GENERAL)
                gen <= reg_wdata;
            if (reg_addr == ADDR_OVERCUR)
                low <= reg_wdata[OCR_RATIO_BIT];
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || reg_wr || !run0)
            on_cnt <= 6'h00;
        else if (on_cnt != 6'h3f)
            on_cnt <= on_cnt + 6'h01;
    end
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || reg_wr || chan_on[0])
            off_cnt <= 6'h00;
        else if (off_cnt != 6'h3f)
            off_cnt <= off_cnt + 6'h01;
    end
    // ----------
    // properties
    // ----------
    property p_ratio;
        reg_wr && reg_addr == ADDR_OVERCUR |=>
            sense_ratio_low == {2{$past(reg_wdata[OCR_RATIO_BIT])}};
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio outputs wrong");
    property p_dir_dis;
        cfg0[CFG_DIR_DIS_BIT] |-> chan_on[0] == pwm_on[0];
    endproperty
    a_dir_dis: assert property (p_dir_dis) else $error("channel not on pwm");
    property p_short_pin;
        (!chan_on[0] && comp_in[0].os_over_thr && !cfg0[CFG_OS_DIS_BIT])[*6] |-> !fault_pin_n;
    endproperty
    a_short_pin: assert property (p_short_pin) else $error("short not on pin");
    property p_olon_pin;
        (!low && chan_on[0] && comp_in[0].olon_under_thr && !cfg0[CFG_ON_OPEN_LOAD_DISABLE_BIT])[*6]
            |-> !fault_pin_n && chan_on[0];
    endproperty
    a_olon_pin: assert property (p_olon_pin) else $error("open load not on pin");
    property p_release;
        (!low && comp_in[0] == 3'b000 && comp_in[1] == 3'b000)[*6] |-> fault_pin_n;
    endproperty
    a_release: assert property (p_release) else $error("pin stuck low");
    property p_on_quiet;
        (!low && chan_on == 2'b11 && !comp_in[0].olon_under_thr
            && !comp_in[1].olon_under_thr)[*6] |-> fault_pin_n;
    endproperty
    a_on_quiet: assert property (p_on_quiet) else $error("off check while on");
    property p_oc_sense;
        (gen[1:0] == SEL_CH0 && oc_window[0])[*6] |-> sense_valid_pin_n && !sense_enable;
    endproperty
    a_oc_sense: assert property (p_oc_sense) else $error("sense during window");
    property p_valid_on;
        on_cnt == 6'd24 |-> !sense_valid_pin_n;
    endproperty
    a_valid_on: assert property (p_valid_on) else $error("sense never valid");
    property p_hold;
        gen[1:0] == SEL_CH0 && off_cnt > 6'd2 |->
            sense_valid_pin_n && (!gen[GEN_TH_EN_BIT] || $stable(sense_out));
    endproperty
    a_hold: assert property (p_hold) else $error("off sense wrong");
    c_hold: cover property (gen[GEN_TH_EN_BIT] && off_cnt == 6'd5);
    c_low_off: cover property (low && $fell(chan_on[0]));
    c_oc: cover property (oc_window[0] && chan_on[0]);
endmodule
bind ldsc_top ldsc_properties #(.SNS_W(SNS_W)) ldsc_properties_i (.sys_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .pwm_on, .comp_in, .oc_window, .chan_on,
    .fault_pin_n, .sense_valid_pin_n, .sense_out, .sense_ratio_low, .sense_enable);
`default_nettype wire

// file: sim/tb.sv
// bench: self-checking test of the diagnostic and sense block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ldsc_pkg::*;
    logic             sys_clk    = 1'b0;
    logic             sys_rst    = 1'b1;
    logic [3:0]       reg_addr   = 4'h0;
    logic [15:0]      reg_wdata  = 16'h0000;
    logic             reg_wr     = 1'b0;
    logic             reg_rd     = 1'b0;
    logic [1:0]       direct_in  = 2'h0;
    logic [1:0]       pwm_on     = 2'h0;
    logic [1:0]       oc_window  = 2'h0;
    logic [1:0]       load_open  = 2'h0;
    logic [1:0]       load_short = 2'h0;
    logic [11:0]      level0     = 12'h000;
    logic [11:0]      level1     = 12'h000;
    logic [11:0]      temp_sense = 12'h000;
    logic             rd_d       = 1'b0;
    logic [15:0]      reg_rdata;
    ldsc_comp_t [1:0] comp_in;
    logic [11:0]      cur_sense0;
    logic [11:0]      cur_sense1;
    logic [11:0]      sense_out;
    logic [1:0]       chan_on;
    logic [1:0]       sense_ratio_low;
    logic             fault_pin_n;
    logic             sense_valid_pin_n;
    logic             sense_enable;
    logic [31:0]      front;
    logic [31:0]      exp_q[$];
    int               err_count   = 0;
    int               checks_done = 0;
    int               seed        = 92;
    ldsc_top #(.OLLED_CYC(50), .SNS_W(12)) ldsc_top_i (.sys_clk, .sys_rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .direct_in, .pwm_on, .comp_in,
        .oc_window, .cur_sense0, .cur_sense1, .temp_sense, .chan_on, .fault_pin_n,
        .sense_valid_pin_n, .sense_out, .sense_ratio_low, .sense_enable);
    ldsc_load_model ldsc_load_model_i (.chan_on, .load_open, .load_short, .level0,
        .level1, .comp_in, .cur_sense0, .cur_sense1);
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ----------
    // tasks
    // ----------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // values as settled before this edge
    task automatic pin(input logic [15:0] got, input logic [15:0] exp);
        chk(got, exp);
        @(posedge sys_clk);
    endtask
    task automatic fp(input logic e);
        pin(16'(fault_pin_n), 16'(e));
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back({m, e & m});
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
    endtask
    task automatic fl(input logic [15:0] e, input logic [15:0] m = 16'hffff);
        rd(ADDR_FAULT_CH0, e, m);
    endtask
    task automatic run(input int n);
        pwm_on <= 2'h1;
        cyc(n);
        pwm_on <= 2'h0;
        cyc(10);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // read data stand one cycle after the strobe
    always @(posedge sys_clk)
    begin
        rd_d <= reg_rd;
        if (rd_d)
        begin
            front = exp_q.pop_front();
            chk(reg_rdata & front[31:16], front[15:0]);
        end
    end
    initial
    begin
        #100000;
        err_count++;
        close_out();
    end
    // ----------
    // main sequence
    // ----------
    initial
    begin
        cyc(10);
        sys_rst <= 1'b0;
        cyc(4);
        for (int a = 0; a < 8; a++)
            rd(4'(a), (a == 6) ? 16'h0004 : 16'h0000);
        wr(4'h7, 16'hffff);
        rd(4'h7, 16'h0000);
        wr(ADDR_CH0_CONFIG, 16'h0021);
        wr(ADDR_CH1_CONFIG, 16'h0021);
        rd(ADDR_CH0_CONFIG, 16'h0021);
        repeat (8)
        begin
            pwm_on <= 2'($random(seed));
            pin(16'(chan_on), 16'(pwm_on));
        end
        pwm_on     <= 2'h0;
        load_short <= 2'h1;
        cyc(8);
        fp(1'b0);
        pwm_on <= 2'h1;
        cyc(8);
        fp(1'b1);
        pin(16'(chan_on), 16'h0001);
        load_short <= 2'h0;
        pwm_on     <= 2'h0;
        cyc(8);
        fp(1'b1);
        fl(16'h0001);
        fl(16'h0000);
        wr(ADDR_CH0_CONFIG, 16'h0061);
        load_short <= 2'h1;
        cyc(8);
        fp(1'b1);
        fl(16'h0000);
        load_short <= 2'h0;
        cyc(4);
        wr(ADDR_CH0_CONFIG, 16'h0021);
        load_open <= 2'h1;
        cyc(8);
        fp(1'b0);
        load_open <= 2'h0;
        cyc(8);
        fp(1'b1);
        fl(16'h0002);
        fl(16'h0000);
        load_open <= 2'h1;
        pwm_on    <= 2'h1;
        cyc(8);
        fp(1'b0);
        fl(16'h0004);
        fl(16'h0004);
        load_open <= 2'h0;
        cyc(8);
        fp(1'b1);
        fl(16'h0004);
        fl(16'h0000);
        load_open <= 2'h1;
        cyc(8);
        pwm_on <= 2'h0;
        cyc(8);
        fl(16'h0006);
        fl(16'h0002);
        wr(ADDR_OVERCUR, 16'h0001);
        cyc(1);
        pin(16'(sense_ratio_low), 16'h0003);
        run(60);
        fl(16'h0004, 16'h0004);
        load_open <= 2'h0;
        fl(16'h0004, 16'h0004);
        run(60);
        fl(16'h0004, 16'h0004);
        fl(16'h0000, 16'h0004);
        load_open <= 2'h1;
        run(10);
        fl(16'h0000, 16'h0004);
        wr(ADDR_CH0_CONFIG, 16'h0020);
        run(60);
        fl(16'h0000, 16'h0004);
        wr(ADDR_CH0_CONFIG, 16'h0001);
        direct_in <= 2'h1;
        cyc(12);
        direct_in <= 2'h0;
        cyc(10);
        fl(16'h0004, 16'h0004);
        load_open <= 2'h0;
        wr(ADDR_CH0_CONFIG, 16'h0021);
        wr(ADDR_OVERCUR, 16'h0000);
        level0     <= 12'($random(seed));
        level1     <= 12'($random(seed));
        temp_sense <= 12'($random(seed));
        wr(ADDR_GENERAL, 16'h0001);
        pwm_on <= 2'h1;
        cyc(30);
        pin(16'(sense_valid_pin_n), 16'h0000);
        pin(16'(sense_out), 16'(level0));
        pwm_on <= 2'h0;
        cyc(4);
        pin(16'(sense_valid_pin_n), 16'h0001);
        wr(ADDR_GENERAL, 16'h0002);
        pwm_on <= 2'h2;
        cyc(30);
        pin(16'(sense_out), 16'(level1));
        wr(ADDR_GENERAL, 16'h0003);
        cyc(4);
        pin(16'(sense_out), 16'(temp_sense));
        pwm_on <= 2'h0;
        // hold mode selected by GEN_TH_EN_BIT alone, whatever the slew setting
        wr(ADDR_GENERAL, 16'h0005);
        run(30);
        pin(16'(sense_out), 16'(level0));
        pin(16'(sense_valid_pin_n), 16'h0001);
        wr(ADDR_GENERAL, 16'h0006);
        cyc(6);
        pin(16'(sense_out), 16'h0000);
        wr(ADDR_GENERAL, 16'h0001);
        pwm_on    <= 2'h1;
        oc_window <= 2'h1;
        cyc(10);
        pin(16'(sense_enable), 16'h0000);
        pin(16'(sense_valid_pin_n), 16'h0001);
        oc_window <= 2'h0;
        cyc(30);
        pin(16'(sense_valid_pin_n), 16'h0000);
        pwm_on <= 2'h0;
        cyc(4);
        close_out();
    end
endmodule
`default_nettype wire
